// [shared/irq_map.vh]
// Purpose: Register offsets, bit positions and reset values of the interrupt block
// Assumes: Byte-wide register port, one register per address
// Notes: Offsets other than the main status register are local choices
`ifndef IRQ_MAP_VH
`define IRQ_MAP_VH
`define ADDR_W 5
`define OFF_MAIN_STATUS 5'h00
`define OFF_ALARM_PF_EN 5'h01
`define OFF_PERIODIC_EN 5'h02
`define OFF_RT_MODE 5'h03
`define OFF_ROUTING 5'h04
`define OFF_IRQ_ENABLE 5'h05
`define OFF_IRQ_STATUS 5'h06
`define OFF_IRQ_CLEAR 5'h07
`define OFF_ALARM_CMP0 5'h08
`define MS_PAGE 7
`define MS_REGSEL 6
`define MS_T1 5
`define MS_T0 4
`define MS_ALARM 3
`define MS_PERIODIC 2
`define MS_PF 1
`define MS_SUMMARY 0
`define EN_PF 7
`define EN_ALARM 6
`define CMP_LO 0
`define CMP_HI 5
`define RTM_STANDBY_IRQ 4
`define RTM_STANDBY_TMR 5
`define PER_T0 6
`define PER_T1 7
`define RST_BYTE 8'h00
`define RST_EV 3'h0
`define N_CMP 6
`define N_SRC 5
`define SRC_PF 0
`define SRC_PER 1
`define SRC_ALARM 2
`define SRC_T0 3
`define SRC_T1 4
`define EV_ALARM 0
`define EV_PF 1
`define EV_STANDBY 2
`endif

// [design/alarm_match.v]
// Purpose: Combines per-counter compare results into one alarm match
// Assumes: Counter and compare bytes arrive already aligned
// Notes: Disabled comparators read as always equal
`timescale 1ns/1ns
`include "irq_map.vh"
module alarm_match #(
  parameter N = `N_CMP
) (
  input wire [N*8-1:0] counters,
  input wire [N*8-1:0] compares,
  input wire [N-1:0] enables,
  output wire match
);
  wire [N-1:0] eq;
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_cmp
      assign eq[i] = ~enables[i] | (counters[i*8+7:i*8] == compares[i*8+7:i*8]);
    end
  endgenerate
  // All disabled gives no alarm, not a permanent match
  assign match = (|enables) & (&eq);
endmodule // alarm_match

// [design/irq_route.v]
// Purpose: Steers each interrupt source to the main or multi-function output
// Assumes: Inputs are pending and enabled levels
// Notes: Purely combinational
`timescale 1ns/1ns
`include "irq_map.vh"
module irq_route #(
  parameter N = `N_SRC
) (
  input wire [N-1:0] pending,
  input wire [N-1:0] route,
  output wire to_main,
  output wire to_mfo
);
  assign to_mfo = |(pending & route);
  assign to_main = |(pending & ~route);
endmodule // irq_route

// [design/rtc_irq_ctrl.v]
// Purpose: Interrupt enables and main status of a clock and timer peripheral
// Assumes: Sources and power state inputs synchronous to SYS_CLK
// Notes: Pin polarity and drive modes handled outside this block
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`include "irq_map.vh"
module rtc_irq_ctrl #(
  parameter N_CMP = `N_CMP
) (
  input wire SYS_CLK,
  input wire SRST,
  input wire [`ADDR_W-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire [N_CMP*8-1:0] COUNTERS,
  input wire PERIODIC_TICK,
  input wire TIMER0_EVENT,
  input wire TIMER1_EVENT,
  input wire POWER_FAIL_INPUT_N,
  input wire BATTERY_MODE,
  input wire ON_BATTERY,
  input wire BATTERY_LOW_RAW,
  output wire LOW_BATTERY_DETECT_EN,
  output reg BATTERY_LOW,
  output wire PAGE_SELECT_BIT,
  output wire REGISTER_SELECT_BIT,
  output wire INTERRUPT_OUTPUT_PIN,
  output wire MULTI_FUNCTION_OUTPUT,
  output wire IRQ
);
  reg [7:0] en_q;
  reg [7:0] per_q;
  reg [7:0] rtm_q;
  reg [7:0] route_q;
  reg [1:0] sel_q;
  reg [3:0] flag_q;
  reg [2:0] ev_q;
  reg [2:0] ev_en_q;
  reg [N_CMP*8-1:0] cmp_q;
  reg match_q;
  reg standby_q;
  reg [7:0] rd_d;
  wire match;
  wire standby;
  wire eff_pf_en;
  wire eff_alarm_en;
  wire eff_t0_en;
  wire eff_t1_en;
  wire eff_per_en;
  wire alarm_rise;
  wire pf_level;
  wire summary;
  wire [`N_SRC-1:0] pend;
  wire to_main;
  wire to_mfo;
  wire [3:0] ms_set;
  wire [3:0] ms_clr;
  wire wr_ms;
  wire standby_entry;
  integer k;
  // Separate loop index keeps the read decode off the clocked process
  integer j;

  function wr_hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    begin
      wr_hit = WR & (a == off);
    end
  endfunction

  assign standby = BATTERY_MODE & ON_BATTERY;
  assign standby_entry = standby & ~standby_q;
  // In standby the enables only act when the standby control bit allows them
  assign eff_pf_en = en_q[`EN_PF] & (~standby | rtm_q[`RTM_STANDBY_IRQ]);
  assign eff_alarm_en = en_q[`EN_ALARM] & (~standby | rtm_q[`RTM_STANDBY_IRQ]);
  assign eff_per_en = |per_q[5:0] & (~standby | rtm_q[`RTM_STANDBY_IRQ]);
  assign eff_t0_en = per_q[`PER_T0] &
    (~standby | (rtm_q[`RTM_STANDBY_IRQ] & rtm_q[`RTM_STANDBY_TMR]));
  assign eff_t1_en = per_q[`PER_T1] &
    (~standby | (rtm_q[`RTM_STANDBY_IRQ] & rtm_q[`RTM_STANDBY_TMR]));

  alarm_match #(
    .N(N_CMP)
  ) u_match (
    .counters(COUNTERS),
    .compares(cmp_q),
    .enables(en_q[`CMP_HI:`CMP_LO]),
    .match(match)
  );

  assign alarm_rise = match & ~match_q;
  assign pf_level = ~POWER_FAIL_INPUT_N;
  // Flags: bit 3 timer1, 2 timer0, 1 alarm, 0 periodic
  assign ms_set = {TIMER1_EVENT, TIMER0_EVENT, alarm_rise, PERIODIC_TICK};
  assign wr_ms = wr_hit(ADDR, `OFF_MAIN_STATUS);
  assign ms_clr = wr_ms ? WDATA[`MS_T1:`MS_PERIODIC] : 4'h0;

  assign pend[`SRC_PF] = pf_level & eff_pf_en;
  assign pend[`SRC_PER] = flag_q[0] & eff_per_en;
  assign pend[`SRC_ALARM] = flag_q[1] & eff_alarm_en;
  assign pend[`SRC_T0] = flag_q[2] & eff_t0_en;
  assign pend[`SRC_T1] = flag_q[3] & eff_t1_en;
  // Summary drops only once every pending source is gone
  assign summary = |pend;

  irq_route #(
    .N(`N_SRC)
  ) u_route (
    .pending(pend),
    .route(route_q[`N_SRC-1:0]),
    .to_main(to_main),
    .to_mfo(to_mfo)
  );

  assign INTERRUPT_OUTPUT_PIN = to_main;
  assign MULTI_FUNCTION_OUTPUT = to_mfo;
  assign PAGE_SELECT_BIT = sel_q[1];
  assign REGISTER_SELECT_BIT = sel_q[0];
  // Detector only powered while power-fail enable stands
  assign LOW_BATTERY_DETECT_EN = eff_pf_en;
  assign IRQ = |(ev_q & ev_en_q);

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      en_q <= `RST_BYTE;
      per_q <= `RST_BYTE;
      rtm_q <= `RST_BYTE;
      route_q <= `RST_BYTE;
      sel_q <= 2'h0;
      flag_q <= 4'h0;
      ev_q <= `RST_EV;
      ev_en_q <= `RST_EV;
      cmp_q <= {N_CMP{8'h00}};
      match_q <= 1'b0;
      standby_q <= 1'b0;
      BATTERY_LOW <= 1'b0;
      RDATA <= `RST_BYTE;
    end else begin
      match_q <= match;
      standby_q <= standby;
      RDATA <= rd_d;
      BATTERY_LOW <= BATTERY_LOW_RAW & eff_pf_en;
      // Set wins over a same-cycle clear
      flag_q <= (flag_q & ~ms_clr) | ms_set;
      if (wr_ms) begin
        sel_q <= {WDATA[`MS_PAGE], WDATA[`MS_REGSEL]};
      end
      if (wr_hit(ADDR, `OFF_ALARM_PF_EN)) begin
        en_q <= WDATA;
      end
      if (wr_hit(ADDR, `OFF_PERIODIC_EN)) begin
        per_q <= WDATA;
      end
      if (wr_hit(ADDR, `OFF_RT_MODE)) begin
        rtm_q <= WDATA;
      end
      if (wr_hit(ADDR, `OFF_ROUTING)) begin
        route_q <= WDATA;
      end
      if (standby_entry & ~rtm_q[`RTM_STANDBY_IRQ]) begin
        per_q <= `RST_BYTE;
        en_q[`EN_PF] <= 1'b0;
        en_q[`EN_ALARM] <= 1'b0;
      end
      for (k = 0; k < N_CMP; k = k + 1) begin
        if (wr_hit(ADDR, `OFF_ALARM_CMP0 + k[`ADDR_W-1:0])) begin
          cmp_q[k*8 +: 8] <= WDATA;
        end
      end
      if (wr_hit(ADDR, `OFF_IRQ_ENABLE)) begin
        ev_en_q <= WDATA[2:0];
      end
      ev_q <= (ev_q & ~(wr_hit(ADDR, `OFF_IRQ_CLEAR) ? WDATA[2:0] : 3'h0)) |
        {standby_entry, pf_level, alarm_rise};
    end
  end

  always @* begin
    rd_d = `RST_BYTE;
    if (RD) begin
      case (ADDR)
        `OFF_MAIN_STATUS: rd_d = {sel_q, flag_q, pf_level, summary};
        `OFF_ALARM_PF_EN: rd_d = en_q;
        `OFF_PERIODIC_EN: rd_d = per_q;
        `OFF_RT_MODE: rd_d = rtm_q;
        `OFF_ROUTING: rd_d = {1'b0, BATTERY_LOW, 1'b0, route_q[4:0]};
        `OFF_IRQ_ENABLE: rd_d = {5'h00, ev_en_q};
        `OFF_IRQ_STATUS: rd_d = {5'h00, ev_q};
        default: begin
          rd_d = `RST_BYTE;
          for (j = 0; j < N_CMP; j = j + 1) begin
            if (ADDR == `OFF_ALARM_CMP0 + j[`ADDR_W-1:0]) begin
              rd_d = cmp_q[j*8 +: 8];
            end
          end
        end
      endcase
    end
  end
endmodule // rtc_irq_ctrl

// [testbench/host_bus_model.sv]
// Purpose: Host side of the byte register port
// Assumes: One-cycle strobes, read data the cycle after the strobe
// Notes: Read data taken mid-cycle, once settled
`timescale 1ns/1ns
module host_bus_model (
  input wire clk,
  output reg [4:0] addr,
  output reg [7:0] wdata,
  output reg wr,
  output reg rd,
  input wire [7:0] rdata
);
  initial begin
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task wr_reg(input [4:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [4:0] a, output [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      // Data stands for one cycle only
      @(negedge clk);
      d = rdata;
    end
  endtask
endmodule // host_bus_model

// [testbench/rtc_irq_ctrl_props.sv]
// Purpose: Port-level checks of the interrupt block
// Assumes: Single clock domain
// Notes: Routing and standby gating are judged by the bench
`timescale 1ns/1ns
module rtc_irq_ctrl_props #(parameter N_CMP = 6) (
  input wire SYS_CLK,
  input wire SRST,
  input wire [4:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire POWER_FAIL_INPUT_N,
  input wire BATTERY_MODE,
  input wire ON_BATTERY,
  input wire BATTERY_LOW_RAW,
  input wire LOW_BATTERY_DETECT_EN,
  input wire BATTERY_LOW,
  input wire PAGE_SELECT_BIT,
  input wire REGISTER_SELECT_BIT,
  input wire INTERRUPT_OUTPUT_PIN,
  input wire MULTI_FUNCTION_OUTPUT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  property p_pf_read;
    $past(RD && ADDR == 5'h00) |-> RDATA[1] == !$past(POWER_FAIL_INPUT_N);
  endproperty
  a_pf_read: assert property (p_pf_read) else $error("pf status bit");
  property p_sum_read;
    $past(RD && ADDR == 5'h00) |->
      RDATA[0] == $past(INTERRUPT_OUTPUT_PIN || MULTI_FUNCTION_OUTPUT);
  endproperty
  a_sum_read: assert property (p_sum_read) else $error("summary bit");
  property p_pf_irq;
    !POWER_FAIL_INPUT_N && LOW_BATTERY_DETECT_EN |-> INTERRUPT_OUTPUT_PIN || MULTI_FUNCTION_OUTPUT;
  endproperty
  a_pf_irq: assert property (p_pf_irq) else $error("pf interrupt missing");
  property p_blow;
    !$past(SRST) |-> BATTERY_LOW == $past(BATTERY_LOW_RAW && LOW_BATTERY_DETECT_EN);
  endproperty
  a_blow: assert property (p_blow) else $error("battery low gating");
  property p_lbe_rise;
    $rose(LOW_BATTERY_DETECT_EN) |->
      $past(WR && (ADDR == 5'h01 || ADDR == 5'h03)) || $past(BATTERY_MODE && ON_BATTERY);
  endproperty
  a_lbe_rise: assert property (p_lbe_rise) else $error("detect enable rose");
  property p_ps_rise;
    $rose(PAGE_SELECT_BIT) |-> $past(WR && ADDR == 5'h00 && WDATA[7])
      || $past(WR && ADDR == 5'h00 && WDATA[7], 2);
  endproperty
  a_ps_rise: assert property (p_ps_rise) else $error("page select rose");
  property p_rs_rise;
    $rose(REGISTER_SELECT_BIT) |-> $past(WR && ADDR == 5'h00 && WDATA[6])
      || $past(WR && ADDR == 5'h00 && WDATA[6], 2);
  endproperty
  a_rs_rise: assert property (p_rs_rise) else $error("reg select rose");
  property p_rd_idle;
    !$past(RD) |-> RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
endmodule // rtc_irq_ctrl_props
bind rtc_irq_ctrl rtc_irq_ctrl_props #(.N_CMP(N_CMP)) props_u (.SYS_CLK(SYS_CLK), .SRST(SRST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .POWER_FAIL_INPUT_N(POWER_FAIL_INPUT_N), .BATTERY_MODE(BATTERY_MODE),
  .ON_BATTERY(ON_BATTERY), .BATTERY_LOW_RAW(BATTERY_LOW_RAW),
  .LOW_BATTERY_DETECT_EN(LOW_BATTERY_DETECT_EN), .BATTERY_LOW(BATTERY_LOW),
  .PAGE_SELECT_BIT(PAGE_SELECT_BIT), .REGISTER_SELECT_BIT(REGISTER_SELECT_BIT),
  .INTERRUPT_OUTPUT_PIN(INTERRUPT_OUTPUT_PIN), .MULTI_FUNCTION_OUTPUT(MULTI_FUNCTION_OUTPUT));

// [testbench/rtc_irq_ctrl_tb_top.sv]
// Purpose: Directed register-level test of the interrupt block
// Assumes: Host model drives the register port
// Notes: Pins packed as ps,rs,int,mfo,irq,lbe,blow,0
`timescale 1ns/1ns
module rtc_irq_ctrl_tb_top;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [47:0] cnt = 48'h0;
  reg tick = 1'b0, t0 = 1'b0, t1 = 1'b0, pfn = 1'b1, bm = 1'b0, ob = 1'b0, braw = 1'b0;
  wire [4:0] a;
  wire [7:0] wd, rdat;
  wire wr, rd, lbe, blow, ps, rs, intp, multi_function_output, irq;
  wire [7:0] pins = {ps, rs, intp, multi_function_output, irq, lbe, blow, 1'b0};
  integer err_total = 0, comparisons = 0, i;
  reg [7:0] v;
  always #10 clk = ~clk;
  host_bus_model host_u (.clk(clk), .addr(a), .wdata(wd), .wr(wr), .rd(rd), .rdata(rdat));
  rtc_irq_ctrl dut_u (.SYS_CLK(clk), .SRST(srst), .ADDR(a), .WDATA(wd), .WR(wr), .RD(rd),
    .RDATA(rdat), .COUNTERS(cnt), .PERIODIC_TICK(tick), .TIMER0_EVENT(t0), .TIMER1_EVENT(t1),
    .POWER_FAIL_INPUT_N(pfn), .BATTERY_MODE(bm), .ON_BATTERY(ob), .BATTERY_LOW_RAW(braw),
    .LOW_BATTERY_DETECT_EN(lbe), .BATTERY_LOW(blow), .PAGE_SELECT_BIT(ps),
    .REGISTER_SELECT_BIT(rs), .INTERRUPT_OUTPUT_PIN(intp), .MULTI_FUNCTION_OUTPUT(multi_function_output),
    .IRQ(irq));
  task chk(input [7:0] s, input [7:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  task rchk(input [4:0] ad, input [7:0] e);
    begin
      host_u.rd_reg(ad, v);
      chk(v, e);
    end
  endtask
  task w(input [4:0] ad, input [7:0] d);
    host_u.wr_reg(ad, d);
  endtask
  // Pins looked at mid-cycle, after the write edge has settled
  task pchk(input [7:0] e);
    begin
      @(negedge clk);
      chk(pins, e);
    end
  endtask
  task test_done;
    begin
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    err_total = err_total + 1;
    test_done;
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 14; i = i + 1) rchk(i[4:0], 8'h00);
    rchk(5'h1f, 8'h00);
    w(5'h09, 8'h55);
    rchk(5'h00, 8'h00);
    w(5'h01, 8'h01);
    rchk(5'h09, 8'h55);
    rchk(5'h00, 8'h08);
    pchk(8'h00);
    w(5'h01, 8'h41);
    rchk(5'h00, 8'h09);
    pchk(8'h20);
    w(5'h04, 8'h04);
    pchk(8'h10);
    w(5'h00, 8'h08);
    rchk(5'h00, 8'h00);
    w(5'h01, 8'h43);
    rchk(5'h00, 8'h00);
    @(posedge clk) cnt[15:8] <= 8'h55;
    rchk(5'h00, 8'h09);
    w(5'h00, 8'h08);
    w(5'h01, 8'h00);
    w(5'h04, 8'h00);
    w(5'h00, 8'hc1);
    rchk(5'h00, 8'hc0);
    pchk(8'hc0);
    w(5'h00, 8'h00);
    @(posedge clk) {tick, t0, t1} <= 3'h7;
    @(posedge clk) {tick, t0, t1} <= 3'h0;
    rchk(5'h00, 8'h34);
    w(5'h02, 8'hc1);
    rchk(5'h00, 8'h35);
    w(5'h00, 8'h34);
    rchk(5'h00, 8'h00);
    w(5'h01, 8'h80);
    pchk(8'h04);
    @(posedge clk) begin
      pfn <= 1'b0;
      braw <= 1'b1;
    end
    rchk(5'h00, 8'h03);
    pchk(8'h26);
    rchk(5'h04, 8'h40);
    // Battery sensing kept, interrupt parked on the second output
    w(5'h04, 8'h01);
    pchk(8'h16);
    w(5'h01, 8'h00);
    rchk(5'h00, 8'h02);
    pchk(8'h00);
    @(posedge clk) begin
      pfn <= 1'b1;
      braw <= 1'b0;
    end
    w(5'h07, 8'h07);
    w(5'h05, 8'h04);
    w(5'h01, 8'hc0);
    w(5'h02, 8'hff);
    @(posedge clk) {bm, ob} <= 2'h3;
    rchk(5'h01, 8'h00);
    rchk(5'h02, 8'h00);
    rchk(5'h06, 8'h04);
    pchk(8'h08);
    w(5'h07, 8'h04);
    pchk(8'h00);
    @(posedge clk) {bm, ob} <= 2'h0;
    w(5'h03, 8'h10);
    w(5'h01, 8'hc0);
    @(posedge clk) {bm, ob} <= 2'h3;
    rchk(5'h01, 8'hc0);
    pchk(8'h0c);
    w(5'h03, 8'h00);
    pchk(8'h08);
    test_done;
  end
endmodule // rtc_irq_ctrl_tb_top
